//--- bench/fsl_host_model.sv
/*
 * host side of the read port: issues register reads and done pulses.
 * assumes the bank answers one cycle after the request edge.
 */
`timescale 1ns/1ps
module fsl_host_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output logic            o_rd_req,
  output logic [7:0]      o_rd_addr,
  output logic            o_rd_done
);
  // idle levels at time zero
  initial begin
    o_rd_req = 1'b0;
    o_rd_addr = 8'h00;
    o_rd_done = 1'b0;
  end
  // one request; answer taken in the following cycle
  task automatic req(input logic [7:0] a, output logic v, output logic [7:0] d);
    @(negedge i_mclk);
    o_rd_req = 1'b1;
    o_rd_addr = a;
    @(negedge i_mclk);
    o_rd_req = 1'b0;
    o_rd_addr = ~a; // no stale address once released
    v = i_rd_valid;
    d = i_rd_data;
  endtask
  // byte has left the host wire
  task automatic done();
    @(negedge i_mclk);
    o_rd_done = 1'b1;
    @(negedge i_mclk);
    o_rd_done = 1'b0;
  endtask
endmodule

//--- bench/tb.sv
/*
 * self-checking bench of the fault status latch bank.
 * assumes the package and the host model are compiled first.
 */
`timescale 1ns/1ps
`include "fsl_params.svh"
module tb;
  typedef struct packed {
    logic [1:0]  kind;
    logic [2:0]  idx;
    logic [15:0] val;
    logic [7:0]  ep;
    logic [7:0]  es;
  } fsl_row_t;
  logic                     i_mclk, i_reset_n, d1, d2, req, done, valid, v;
  logic [7:0]               addr, data, d;
  fsl_pkg::fsl_chan_t [4:0] volt;
  fsl_pkg::fsl_chan_t [2:0] temp;
  fsl_pkg::fsl_tach_t [3:0] tach;
  int                       bad_count, n_compared;
  fsl_row_t                 rows [15];
  fsl_fault_status_latch_bank i_fsl_fault_status_latch_bank (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_volt(volt), .i_temp(temp), .i_tach(tach),
    .i_remote_diode_1_fault(d1), .i_remote_diode_2_fault(d2), .i_rd_req(req),
    .i_rd_addr(addr), .i_rd_done(done), .o_rd_valid(valid), .o_rd_data(data));
  fsl_host_model i_fsl_host_model (.i_mclk(i_mclk), .i_rd_valid(valid),
    .i_rd_data(data), .o_rd_req(req), .o_rd_addr(addr), .o_rd_done(done));
  // kind: 0 supply, 1 zone, 2 fan, 3 diode; signed zone limits -50..60
  initial rows = '{{2'd0, 3'd0, 16'h0040, 8'h01, 8'h00},
    {2'd0, 3'd1, 16'h00c1, 8'h02, 8'h00}, {2'd0, 3'd2, 16'h00c0, 8'h00, 8'h00},
    {2'd0, 3'd3, 16'h003f, 8'h08, 8'h00}, {2'd0, 3'd4, 16'h0040, 8'h00, 8'h00},
    {2'd0, 3'd4, 16'h00c1, 8'h80, 8'h01}, {2'd1, 3'd0, 16'h00cd, 8'h10, 8'h00},
    {2'd1, 3'd1, 16'h00ce, 8'h20, 8'h00}, {2'd1, 3'd2, 16'h003d, 8'h40, 8'h00},
    {2'd2, 3'd0, 16'h1001, 8'h80, 8'h04}, {2'd2, 3'd1, 16'h1000, 8'h00, 8'h00},
    {2'd2, 3'd2, 16'hffff, 8'h80, 8'h10}, {2'd2, 3'd3, 16'h2000, 8'h80, 8'h20},
    {2'd3, 3'd0, 16'h0001, 8'h90, 8'h40}, {2'd3, 3'd1, 16'h0001, 8'hc0, 8'h80}};
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // full read: answer, then done so clearing may follow
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_fsl_host_model.req(a, v, d);
    chk("valid", 8'h01, {7'h00, v});
    chk("data", e, d);
    i_fsl_host_model.done();
  endtask
  // all readings inside their windows
  task automatic base();
    for (int i = 0; i < 5; i++) volt[i] = '{8'h80, 8'h40, 8'hc0};
    for (int i = 0; i < 3; i++) temp[i] = '{8'h19, 8'hce, 8'h3c};
    for (int i = 0; i < 4; i++) tach[i] = '{16'h0100, 16'h1000};
    d1 = 1'b0;
    d2 = 1'b0;
  endtask
  task automatic poke(input fsl_row_t r);
    @(negedge i_mclk);
    case (r.kind)
      2'd0: volt[r.idx].value = r.val[7:0];
      2'd1: temp[r.idx].value = r.val[7:0];
      2'd2: tach[r.idx].count = r.val;
      default: if (r.idx == 3'd0) d1 = 1'b1; else d2 = 1'b1;
    endcase
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // watchdog: the run needs well under 2000 cycles
  initial begin
    #80000;
    bad_count++;
    conclude();
  end
  initial begin
    bad_count = 0;
    n_compared = 0;
    i_reset_n = 1'b0;
    base();
    repeat (5) @(negedge i_mclk);
    i_reset_n = 1'b1;
    rd(`FSL_OFS_PRIMARY, `FSL_RST_PRIMARY);
    rd(`FSL_OFS_SECONDARY, `FSL_RST_SECONDARY);
    foreach (rows[k]) begin
      poke(rows[k]);
      repeat (2) @(negedge i_mclk);
      rd(8'h41, rows[k].ep);
      rd(8'h42, rows[k].es);
      base();
      rd(8'h41, rows[k].ep);
      rd(8'h42, rows[k].es);
      rd(8'h41, 8'h00);
      rd(8'h42, 8'h00);
    end
    // several faults, registers cleared one at a time
    poke(rows[0]);
    poke(rows[12]);
    // let the fan fault reach a clock edge before it goes away
    @(negedge i_mclk);
    base();
    // primary read left unfinished, so its flags are not cleared yet
    i_fsl_host_model.req(8'h41, v, d);
    chk("multi valid", 8'h01, {7'h00, v});
    chk("multi data", 8'h81, d);
    rd(8'h42, 8'h20);
    rd(8'h41, 8'h01);
    rd(8'h41, 8'h00);
    // unmapped offset is not answered
    i_fsl_host_model.req(8'h43, v, d);
    chk("unmapped valid", 8'h00, {7'h00, v});
    chk("unmapped data", 8'h00, d);
    // brief fault between capture and done must survive
    i_fsl_host_model.req(8'h42, v, d);
    chk("snap", 8'h00, d);
    d2 = 1'b1;
    @(negedge i_mclk);
    d2 = 1'b0;
    i_fsl_host_model.done();
    rd(8'h42, 8'h80);
    rd(8'h42, 8'h00);
    rd(8'h41, 8'h40);
    // reset in mid-run with a flag latched
    poke(rows[13]);
    repeat (2) @(negedge i_mclk);
    base();
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_reset_n = 1'b1;
    rd(8'h41, 8'h00);
    rd(8'h42, 8'h00);
    conclude();
  end
endmodule

//--- pkg/fsl_params.svh
/*
 * constants of the fault status latch bank: register offsets, reset values, bit positions.
 * assumes it is included by bare name from the package and the design file.
 */
`ifndef FSL_PARAMS_SVH
`define FSL_PARAMS_SVH

// *****************************
// register map
// *****************************
`define FSL_OFS_PRIMARY     8'h41
`define FSL_OFS_SECONDARY   8'h42
`define FSL_RST_PRIMARY     8'h00
`define FSL_RST_SECONDARY   8'h00

// *****************************
// primary register fields
// *****************************
`define FSL_P_ZONE1_BIT     4
`define FSL_P_ZONE2_BIT     5
`define FSL_P_ZONE3_BIT     6
`define FSL_P_SUMMARY_BIT   7

// *****************************
// secondary register fields
// *****************************
`define FSL_S_V12_BIT       0
`define FSL_S_RSVD_BIT      1
`define FSL_S_FAN_LSB       2
`define FSL_S_DIODE1_BIT    6
`define FSL_S_DIODE2_BIT    7

// *****************************
// channel counts
// *****************************
`define FSL_NUM_VOLT        5
`define FSL_NUM_TEMP        3
`define FSL_NUM_FAN         4
`define FSL_V12_IDX         4

`endif

//--- pkg/fsl_pkg.sv
/*
 * types of the fault status latch bank.
 * assumes fsl_params.svh is on the include path.
 */
`include "fsl_params.svh"

package fsl_pkg;

  // one 8-bit reading with its limit window
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] low;
    logic [7:0] high;
  } fsl_chan_t;

  // one tachometer count with its programmed minimum
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] minimum;
  } fsl_tach_t;

endpackage

//--- verilog/fsl_fault_status_latch_bank.sv
/*
 * fault status latch bank: two clear-on-read fault status bytes of a hardware monitor.
 * assumes the serial engine presents register reads as a request pulse with an address
 * and later a done pulse once the data byte has gone out; all inputs are synchronous to
 * i_mclk. readings and limits come from the converter and limit registers elsewhere.
 */
`timescale 1ns/1ps
`include "fsl_params.svh"

module fsl_fault_status_latch_bank (
  input  wire logic                                    i_mclk,
  input  wire logic                                    i_reset_n,
  input  wire fsl_pkg::fsl_chan_t [`FSL_NUM_VOLT-1:0]  i_volt,
  input  wire fsl_pkg::fsl_chan_t [`FSL_NUM_TEMP-1:0]  i_temp,
  input  wire fsl_pkg::fsl_tach_t [`FSL_NUM_FAN-1:0]   i_tach,
  input  wire logic                                    i_remote_diode_1_fault,
  input  wire logic                                    i_remote_diode_2_fault,
  input  wire logic                                    i_rd_req,
  input  wire logic [7:0]                              i_rd_addr,
  input  wire logic                                    i_rd_done,
  output logic                                         o_rd_valid,
  output logic [7:0]                                   o_rd_data
);

  // *****************************
  // fault conditions
  // *****************************
  logic [`FSL_NUM_VOLT-1:0] volt_out;
  logic [`FSL_NUM_TEMP-1:0] temp_out;
  logic [`FSL_NUM_FAN-1:0]  fan_stall;
  logic [6:0]               cond_pri;
  logic [7:0]               cond_sec;

  // window compares per supply and zone channel, a single limit compare per fan
  genvar gi;
  generate
    for (gi = 0; gi < `FSL_NUM_VOLT; gi++) begin : g_volt
      if (gi == `FSL_V12_IDX) begin : g_strict
        assign volt_out[gi] = (i_volt[gi].value < i_volt[gi].low) ||
                              (i_volt[gi].value > i_volt[gi].high);
      end else begin : g_incl
        assign volt_out[gi] = (i_volt[gi].value <= i_volt[gi].low) ||
                              (i_volt[gi].value > i_volt[gi].high);
      end
    end
    for (gi = 0; gi < `FSL_NUM_TEMP; gi++) begin : g_temp
      assign temp_out[gi] = ($signed(i_temp[gi].value) <= $signed(i_temp[gi].low)) ||
                            ($signed(i_temp[gi].value) > $signed(i_temp[gi].high));
    end
    for (gi = 0; gi < `FSL_NUM_FAN; gi++) begin : g_fan
      // count above minimum means slow fan
      assign fan_stall[gi] = i_tach[gi].count > i_tach[gi].minimum;
    end
  endgenerate

  // zone flags, diode faults fold in
  assign cond_pri = {temp_out[2] | i_remote_diode_2_fault,
                     temp_out[1],
                     temp_out[0] | i_remote_diode_1_fault,
                     volt_out[3:0]};

  // secondary layout, reserved bit tied low
  assign cond_sec = {i_remote_diode_2_fault, i_remote_diode_1_fault, fan_stall,
                     1'b0, volt_out[`FSL_V12_IDX]};

  // *****************************
  // read tracking
  // *****************************
  logic [6:0] stat_pri_q;
  logic [7:0] stat_sec_q;
  logic [7:0] snap_pri_q;
  logic [7:0] snap_sec_q;
  logic       pend_pri_q;
  logic       pend_sec_q;
  logic       hit_pri;
  logic       hit_sec;
  logic [7:0] view_pri;
  logic       clr_pri;
  logic       clr_sec;

  assign hit_pri  = i_rd_req && (i_rd_addr == `FSL_OFS_PRIMARY);
  assign hit_sec  = i_rd_req && (i_rd_addr == `FSL_OFS_SECONDARY);
  // summary follows the secondary byte live
  assign view_pri = {|stat_sec_q, stat_pri_q};
  assign clr_pri  = i_rd_done && pend_pri_q;
  assign clr_sec  = i_rd_done && pend_sec_q;

  // remember what was handed out; a new request replaces an unfinished one
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_pri_q <= 1'b0;
      pend_sec_q <= 1'b0;
      snap_pri_q <= `FSL_RST_PRIMARY;
      snap_sec_q <= `FSL_RST_SECONDARY;
    end else begin
      if (i_rd_req) begin
        pend_pri_q <= hit_pri;
        pend_sec_q <= hit_sec;
        snap_pri_q <= view_pri;
        snap_sec_q <= stat_sec_q;
      end else if (i_rd_done) begin
        pend_pri_q <= 1'b0;
        pend_sec_q <= 1'b0;
      end
    end
  end

  // read data; no write path exists, so writes cannot disturb the flags
  // read only
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 8'h00;
    end else begin
      o_rd_valid <= hit_pri || hit_sec;
      o_rd_data  <= hit_pri ? view_pri : (hit_sec ? stat_sec_q : 8'h00);
    end
  end

  // *****************************
  // flag latches
  // *****************************
  // only bits shown in the snapshot may clear, so a fault that arrived after the byte
  // was captured survives the clear; a live condition always wins over the clear
  // sticky set, clear after done
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_pri_q <= 7'(`FSL_RST_PRIMARY);
    end else begin
      stat_pri_q <= (stat_pri_q & ~(clr_pri ? snap_pri_q[6:0] : 7'h00)) | cond_pri;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_sec_q <= `FSL_RST_SECONDARY;
    end else begin
      stat_sec_q <= ((stat_sec_q & ~(clr_sec ? snap_sec_q : 8'h00)) | cond_sec) & 8'hfd;
    end
  end

  // *****************************
  // assertions
  // *****************************
  sequence s_rd_pri;
    i_rd_req && (i_rd_addr == `FSL_OFS_PRIMARY) ##1 o_rd_valid;
  endsequence

  AST_SET_FLAG: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (|cond_sec) |=> (|stat_sec_q))
    else $error("fault condition did not latch a secondary flag");

  AST_HOLD_FLAG: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (stat_pri_q[0] && !clr_pri) |=> stat_pri_q[0])
    else $error("primary flag dropped without a finished read");

  AST_CLEAR_GONE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (clr_sec && snap_sec_q[2] && !cond_sec[2]) |=> !stat_sec_q[2])
    else $error("read flag with gone fault stayed set");

  AST_READ_ALL: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_rd_pri |-> (o_rd_data == $past(view_pri)))
    else $error("primary read did not return every latched flag");

  AST_V25_LOW: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_volt[0].value == i_volt[0].low) |=> stat_pri_q[0])
    else $error("supply at its low limit did not flag");

  AST_ZONE2_SIGNED: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    ($signed(i_temp[1].value) > $signed(i_temp[1].high)) |=> stat_pri_q[`FSL_P_ZONE2_BIT])
    else $error("internal temperature above high did not flag");

  AST_SUMMARY: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    hit_pri |=> (o_rd_data[`FSL_P_SUMMARY_BIT] == $past(|stat_sec_q)))
    else $error("summary bit disagrees with secondary register");

  AST_V12_EDGE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    ((i_volt[4].value == i_volt[4].low) && (i_volt[4].value <= i_volt[4].high) &&
     !stat_sec_q[0] && !i_rd_req) |=> !stat_sec_q[0])
    else $error("12V at its low limit flagged");

  AST_DIODE1: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_remote_diode_1_fault |=> (stat_sec_q[`FSL_S_DIODE1_BIT] && stat_pri_q[`FSL_P_ZONE1_BIT]))
    else $error("diode 1 fault did not set both flags");

  AST_DIODE2: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_remote_diode_2_fault |=> (stat_sec_q[`FSL_S_DIODE2_BIT] && stat_pri_q[`FSL_P_ZONE3_BIT]))
    else $error("diode 2 fault did not set both flags");

  AST_NO_EARLY_CLR: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (hit_sec && stat_sec_q[5] && !i_rd_done) |=> stat_sec_q[5] [*1] ##0 o_rd_data[5])
    else $error("flag cleared before the byte was returned");

  AST_RSVD_ZERO: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_rd_valid |-> !(pend_sec_q && o_rd_data[`FSL_S_RSVD_BIT]))
    else $error("reserved secondary bit read as one");

endmodule
